// >>> rtl/cfam_pkg.sv
package cfam_pkg;

  // ==========================================================================
  // Address space
  // ==========================================================================
  localparam int unsigned CFAM_ADDR_W     = 24;
  localparam logic [23:0] CFAM_SFA_LO     = 24'h000000;
  localparam logic [23:0] CFAM_SFA_HI     = 24'h0003ff;
  localparam logic [23:0] CFAM_RAM_BASE   = 24'h000400;
  localparam logic [23:0] CFAM_SPACE_TOP  = 24'hffffff;
  localparam logic [23:0] CFAM_VEC_LO     = 24'hfffe00;
  localparam logic [23:0] CFAM_RAM_SIZE   = 24'h002800;
  localparam logic [23:0] CFAM_ROM_SIZE   = 24'h020000;
  localparam logic [23:0] CFAM_SFA_SIZE   = 24'h000400;

  // ==========================================================================
  // APB register offsets
  // ==========================================================================
  localparam logic [11:0] CFAM_OFF_FLAG      = 12'h000;
  localparam logic [11:0] CFAM_OFF_ALU_CTRL  = 12'h004;
  localparam logic [11:0] CFAM_OFF_OPERAND_A = 12'h008;
  localparam logic [11:0] CFAM_OFF_OPERAND_B = 12'h00c;
  localparam logic [11:0] CFAM_OFF_RESULT    = 12'h010;
  localparam logic [11:0] CFAM_OFF_PROBE     = 12'h014;
  localparam logic [11:0] CFAM_OFF_REGION    = 12'h018;
  localparam logic [11:0] CFAM_OFF_STATUS    = 12'h01c;
  localparam logic [11:0] CFAM_OFF_BANK_LO   = 12'h040;
  localparam logic [11:0] CFAM_OFF_BANK_HI   = 12'h05c;

  // ==========================================================================
  // Flag register layout
  // ==========================================================================
  localparam int unsigned CFAM_BIT_C       = 0;
  localparam int unsigned CFAM_BIT_D       = 1;
  localparam int unsigned CFAM_BIT_Z       = 2;
  localparam int unsigned CFAM_BIT_S       = 3;
  localparam int unsigned CFAM_BIT_B       = 4;
  localparam int unsigned CFAM_BIT_O       = 5;
  localparam int unsigned CFAM_BIT_I       = 6;
  localparam int unsigned CFAM_BIT_U       = 7;
  localparam int unsigned CFAM_BIT_PRI_LSB = 12;
  localparam int unsigned CFAM_PRI_W       = 3;
  localparam logic [15:0] CFAM_FLAG_WMASK  = 16'h70ff;
  localparam logic [15:0] CFAM_FLAG_RESET  = 16'h0000;

  // ==========================================================================
  // Arithmetic control fields
  // ==========================================================================
  localparam int unsigned CFAM_CTRL_GO     = 0;
  localparam int unsigned CFAM_CTRL_OP_LSB = 1;
  localparam logic [1:0]  CFAM_OP_ADD      = 2'h0;
  localparam logic [1:0]  CFAM_OP_SUB      = 2'h1;
  localparam logic [1:0]  CFAM_OP_ADC      = 2'h2;
  localparam logic [1:0]  CFAM_OP_SBB      = 2'h3;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [4:0] {
    CFAM_REGION_NONE   = 5'b00001,
    CFAM_REGION_SFA    = 5'b00010,
    CFAM_REGION_RAM    = 5'b00100,
    CFAM_REGION_ROM    = 5'b01000,
    CFAM_REGION_VECTOR = 5'b10000
  } cfam_region_type;

  typedef enum logic [1:0] {
    CFAM_ST_RUN  = 2'b01,
    CFAM_ST_TRAP = 2'b10
  } cfam_step_type;

  typedef struct packed {
    logic [2:0] pri;
    logic       u;
    logic       i;
    logic       o;
    logic       b;
    logic       s;
    logic       z;
    logic       d;
    logic       c;
  } cfam_flags_type;

  typedef struct packed {
    logic [11:0] addr;
    logic        write;
    logic [31:0] wdata;
  } cfam_apb_req_type;

endpackage

// >>> rtl/cfam_bank_regs.sv
`timescale 1ns/1ps
module cfam_bank_regs
  import cfam_pkg::*;
#(
  parameter int unsigned NUM_REGS  = 8,
  parameter int unsigned DATA_REGS = 4,
  parameter int unsigned REG_W     = 24,
  parameter int unsigned DATA_W    = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              bank_sel,
  input  wire logic              wr_en,
  input  wire logic [2:0]        idx,
  input  wire logic [REG_W-1:0]  wdata,
  output logic      [REG_W-1:0]  rdata
);

  if (NUM_REGS != 8 || DATA_REGS > NUM_REGS || DATA_W > REG_W) begin : g_chk
    $error("cfam_bank_regs: unsupported register geometry");
  end

  logic [REG_W-1:0] regs_q [2*NUM_REGS];

  // Data registers are narrower than address and base registers.
  function automatic logic [REG_W-1:0] fit(input logic [2:0] i, input logic [REG_W-1:0] v);
    logic [REG_W-1:0] m;
    m = '1;
    if (32'(i) < DATA_REGS) begin
      m = REG_W'((1 << DATA_W) - 1);
    end
    return v & m;
  endfunction

  // ==========================================================================
  // Two copies of each register, the bank flag picks the copy
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < 2 * NUM_REGS; k++) begin
        regs_q[k] <= '0;
      end
    end else if (wr_en) begin
      regs_q[{bank_sel, idx}] <= fit(idx, wdata); // RL5 RL15
    end
  end

  assign rdata = regs_q[{bank_sel, idx}]; // RL5 RL15

endmodule

// >>> rtl/cfam_addr_map.sv
`timescale 1ns/1ps
module cfam_addr_map
  import cfam_pkg::*;
#(
  parameter logic [23:0] RAM_SIZE = CFAM_RAM_SIZE,
  parameter logic [23:0] ROM_SIZE = CFAM_ROM_SIZE,
  parameter logic [23:0] SFA_SIZE = CFAM_SFA_SIZE
) (
  input  wire logic [23:0]     addr,
  output cfam_region_type      region,
  output logic                 sfa_impl
);

  localparam logic [23:0] ROM_LO = 24'(CFAM_SPACE_TOP - ROM_SIZE + 24'h000001);
  localparam logic [23:0] RAM_HI = 24'(CFAM_RAM_BASE + RAM_SIZE - 24'h000001);
  localparam logic [23:0] SFA_IMPL_LO = 24'(CFAM_SFA_HI - SFA_SIZE + 24'h000001);

  if (SFA_SIZE == 0 || SFA_SIZE > CFAM_SFA_SIZE || RAM_SIZE == 0 || ROM_SIZE == 0
      || RAM_HI >= ROM_LO) begin : g_chk
    $error("cfam_addr_map: memory sizes overlap or exceed the space");
  end

  // ==========================================================================
  // Region decode; the vector area wins over the top of ROM
  // ==========================================================================
  always_comb begin
    region = CFAM_REGION_NONE;
    if (addr <= CFAM_SFA_HI) begin
      region = CFAM_REGION_SFA; // RL11
    end else if (addr >= CFAM_VEC_LO) begin
      region = CFAM_REGION_VECTOR; // RL14
    end else if (addr >= ROM_LO) begin
      region = CFAM_REGION_ROM; // RL13
    end else if (addr >= CFAM_RAM_BASE && addr <= RAM_HI) begin
      region = CFAM_REGION_RAM; // RL12
    end
  end

  assign sfa_impl = (addr <= CFAM_SFA_HI) && (addr >= SFA_IMPL_LO); // RL11

endmodule

// >>> rtl/cfam_core.sv
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
// Contract
// (RL1) Priority level field holds levels 0 to 7; bigger value is higher priority.
// (RL2) Stack select flag clear picks interrupt stack, set picks user stack.
// (RL3) Maskable interrupts accepted only while interrupt enable flag is one.
// (RL4) Overflow flag set on signed arithmetic overflow, cleared otherwise.
// (RL5) Bank flag zero routes register accesses to bank 0, one to bank 1.
// (RL6) Sign flag set for negative result, cleared for positive.
// (RL7) Zero flag set when the result equals zero, cleared otherwise.
// (RL8) Debug flag set means a debug trap after every instruction.
// (RL9) Carry flag captures carry of additions and borrow of subtractions.
// (RL10) Linear 16-Mbyte space with 24-bit addresses from zero upward.
// (RL11) 000000H to 0003FFH is the special function area, filled from its top.
// (RL12) Internal RAM starts at 00400H and grows upward.
// (RL13) Internal ROM ends at the top of the space and grows downward.
// (RL14) FFFE00H to FFFFFFH is the fixed vector area.
// (RL15) Eight general registers exist twice; the bank flag picks the copy.
// (RL16) Priority field is three bits; unassigned flag bits read zero, ignore writes.
module cfam_core
  import cfam_pkg::*;
#(
  parameter logic [23:0] RAM_SIZE = CFAM_RAM_SIZE,
  parameter logic [23:0] ROM_SIZE = CFAM_ROM_SIZE,
  parameter logic [23:0] SFA_SIZE = CFAM_SFA_SIZE
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   irq_req,
  input  wire logic [CFAM_PRI_W-1:0]  irq_level,
  output logic                        irq_accept,
  output logic                        user_stack_sel,
  output logic                        bank_sel,
  input  wire logic                   instr_done,
  input  wire logic                   trap_ack,
  output logic                        debug_trap,
  input  wire logic [CFAM_ADDR_W-1:0] cpu_addr,
  output cfam_region_type             cpu_region,
  output logic                        cpu_sfa_impl
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  cfam_apb_req_type req;
  cfam_flags_type   flags_q;
  cfam_flags_type   flags_d;
  cfam_step_type    step_q;
  cfam_step_type    step_d;
  cfam_region_type  probe_region;
  cfam_region_type  cpu_region_c;
  logic [15:0]      operand_a_q;
  logic [15:0]      operand_b_q;
  logic [15:0]      result_q;
  logic [2:0]       alu_op_q;
  logic [23:0]      probe_q;
  logic [31:0]      prdata_q;
  logic             pslverr_q;
  logic             setup;
  logic             access;
  logic             wr;
  logic             alu_go;
  logic [1:0]       alu_op;
  logic [16:0]      alu_sum;
  logic [15:0]      alu_res;
  logic             alu_carry;
  logic             alu_ovf;
  logic             bank_wr;
  logic [23:0]      bank_rdata;
  logic             probe_impl;
  logic             cpu_sfa_impl_c;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic in_bank(input logic [11:0] a);
    return (a >= CFAM_OFF_BANK_LO) && (a <= CFAM_OFF_BANK_HI) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    logic hit;
    hit = in_bank(a);
    if (a == CFAM_OFF_FLAG || a == CFAM_OFF_ALU_CTRL || a == CFAM_OFF_OPERAND_A
        || a == CFAM_OFF_OPERAND_B || a == CFAM_OFF_RESULT || a == CFAM_OFF_PROBE
        || a == CFAM_OFF_REGION || a == CFAM_OFF_STATUS) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  function automatic logic [15:0] pack_flags(input cfam_flags_type f);
    logic [15:0] v;
    v = 16'h0000;
    v[CFAM_BIT_C] = f.c;
    v[CFAM_BIT_D] = f.d;
    v[CFAM_BIT_Z] = f.z;
    v[CFAM_BIT_S] = f.s;
    v[CFAM_BIT_B] = f.b;
    v[CFAM_BIT_O] = f.o;
    v[CFAM_BIT_I] = f.i;
    v[CFAM_BIT_U] = f.u;
    v[CFAM_BIT_PRI_LSB +: CFAM_PRI_W] = f.pri;
    return v;
  endfunction

  function automatic cfam_flags_type unpack_flags(input logic [15:0] v);
    cfam_flags_type f;
    f.c   = v[CFAM_BIT_C];
    f.d   = v[CFAM_BIT_D];
    f.z   = v[CFAM_BIT_Z];
    f.s   = v[CFAM_BIT_S];
    f.b   = v[CFAM_BIT_B];
    f.o   = v[CFAM_BIT_O];
    f.i   = v[CFAM_BIT_I];
    f.u   = v[CFAM_BIT_U];
    f.pri = v[CFAM_BIT_PRI_LSB +: CFAM_PRI_W];
    return f;
  endfunction

  // ==========================================================================
  // APB handshake
  // ==========================================================================
  assign req.addr  = paddr;
  assign req.write = pwrite;
  assign req.wdata = pwdata;
  assign setup     = psel && !penable;
  assign access    = psel && penable;
  assign wr        = access && req.write && mapped(req.addr);
  // Every access completes at once; read data is caught in the setup cycle.
  assign pready    = access;
  assign prdata    = prdata_q;
  assign pslverr   = access && pslverr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= !mapped(req.addr);
    end
  end

  // ==========================================================================
  // Read mux, sampled in the setup phase
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (setup) begin
      prdata_q <= 32'h00000000;
      if (req.write) begin
        prdata_q <= 32'h00000000;
      end else if (req.addr == CFAM_OFF_FLAG) begin
        prdata_q <= {16'h0000, pack_flags(flags_q)}; // RL16
      end else if (req.addr == CFAM_OFF_ALU_CTRL) begin
        prdata_q <= {29'h0, alu_op_q};
      end else if (req.addr == CFAM_OFF_OPERAND_A) begin
        prdata_q <= {16'h0000, operand_a_q};
      end else if (req.addr == CFAM_OFF_OPERAND_B) begin
        prdata_q <= {16'h0000, operand_b_q};
      end else if (req.addr == CFAM_OFF_RESULT) begin
        prdata_q <= {16'h0000, result_q};
      end else if (req.addr == CFAM_OFF_PROBE) begin
        prdata_q <= {8'h00, probe_q};
      end else if (req.addr == CFAM_OFF_REGION) begin
        prdata_q <= {26'h0, probe_impl, probe_region};
      end else if (req.addr == CFAM_OFF_STATUS) begin
        prdata_q <= {27'h0, step_q == CFAM_ST_TRAP, irq_accept,
                     flags_q.b, flags_q.u, flags_q.i};
      end else if (in_bank(req.addr)) begin
        prdata_q <= {8'h00, bank_rdata}; // RL15
      end
    end
  end

  // ==========================================================================
  // Arithmetic unit that drives the condition flags
  // ==========================================================================
  assign alu_go = wr && req.addr == CFAM_OFF_ALU_CTRL && req.wdata[CFAM_CTRL_GO];
  assign alu_op = req.wdata[CFAM_CTRL_OP_LSB +: 2];

  always_comb begin
    alu_sum = 17'h0;
    alu_ovf = 1'b0;
    if (alu_op == CFAM_OP_ADD || alu_op == CFAM_OP_ADC) begin
      alu_sum = {1'b0, operand_a_q} + {1'b0, operand_b_q}
              + {16'h0000, alu_op == CFAM_OP_ADC && flags_q.c};
      alu_ovf = (operand_a_q[15] == operand_b_q[15]) && (alu_sum[15] != operand_a_q[15]);
    end else begin
      alu_sum = {1'b0, operand_a_q} - {1'b0, operand_b_q}
              - {16'h0000, alu_op == CFAM_OP_SBB && flags_q.c};
      alu_ovf = (operand_a_q[15] != operand_b_q[15]) && (alu_sum[15] != operand_a_q[15]);
    end
  end

  assign alu_res   = alu_sum[15:0];
  // In subtraction the seventeenth bit is the borrow, held as carry set.
  assign alu_carry = alu_sum[16]; // RL9

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operand_a_q <= 16'h0000;
      operand_b_q <= 16'h0000;
    end else if (wr && req.addr == CFAM_OFF_OPERAND_A) begin
      operand_a_q <= req.wdata[15:0];
    end else if (wr && req.addr == CFAM_OFF_OPERAND_B) begin
      operand_b_q <= req.wdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= 16'h0000;
      alu_op_q <= 3'h0;
    end else if (wr && req.addr == CFAM_OFF_ALU_CTRL) begin
      alu_op_q <= {alu_op, 1'b0};
      if (alu_go) begin
        result_q <= alu_res;
      end
    end
  end

  // ==========================================================================
  // Flag register
  // ==========================================================================
  always_comb begin
    flags_d = flags_q;
    if (wr && req.addr == CFAM_OFF_FLAG) begin
      flags_d = unpack_flags(req.wdata[15:0] & CFAM_FLAG_WMASK); // RL1 RL16
    end else if (alu_go) begin
      flags_d.c = alu_carry; // RL9
      flags_d.o = alu_ovf; // RL4
      flags_d.s = alu_res[15]; // RL6
      flags_d.z = (alu_res == 16'h0000); // RL7
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= unpack_flags(CFAM_FLAG_RESET);
    end else begin
      flags_q <= flags_d;
    end
  end

  // ==========================================================================
  // Interrupt gating and stack selection
  // ==========================================================================
  // A request must outrank the current level strictly, so level 0 never enters.
  assign irq_accept     = irq_req && flags_q.i && (irq_level > flags_q.pri); // RL3 RL1
  assign user_stack_sel = flags_q.u; // RL2
  assign bank_sel       = flags_q.b; // RL5

  // ==========================================================================
  // Single-step trap sequencer
  // ==========================================================================
  always_comb begin
    step_d = step_q;
    case (step_q)
      CFAM_ST_RUN: begin
        if (instr_done && flags_q.d) begin
          step_d = CFAM_ST_TRAP; // RL8
        end
      end
      CFAM_ST_TRAP: begin
        if (trap_ack) begin
          step_d = CFAM_ST_RUN;
        end
      end
      default: begin
        step_d = CFAM_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_q <= CFAM_ST_RUN;
    end else begin
      step_q <= step_d;
    end
  end

  assign debug_trap = (step_q == CFAM_ST_TRAP); // RL8

  // ==========================================================================
  // Banked general registers
  // ==========================================================================
  assign bank_wr = wr && in_bank(req.addr);

  cfam_bank_regs u_bank (
    .pclk     (pclk),
    .presetn  (presetn),
    .bank_sel (flags_q.b),
    .wr_en    (bank_wr),
    .idx      (req.addr[4:2]),
    .wdata    (req.wdata[23:0]),
    .rdata    (bank_rdata)
  ); // RL15

  // ==========================================================================
  // Address map: a software probe and the live core address
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      probe_q <= 24'h000000;
    end else if (wr && req.addr == CFAM_OFF_PROBE) begin
      probe_q <= req.wdata[CFAM_ADDR_W-1:0]; // RL10
    end
  end

  cfam_addr_map #(
    .RAM_SIZE (RAM_SIZE),
    .ROM_SIZE (ROM_SIZE),
    .SFA_SIZE (SFA_SIZE)
  ) u_map_probe (
    .addr     (probe_q),
    .region   (probe_region),
    .sfa_impl (probe_impl)
  );

  cfam_addr_map #(
    .RAM_SIZE (RAM_SIZE),
    .ROM_SIZE (ROM_SIZE),
    .SFA_SIZE (SFA_SIZE)
  ) u_map_cpu (
    .addr     (cpu_addr),
    .region   (cpu_region_c),
    .sfa_impl (cpu_sfa_impl_c)
  );

  // The live decode is registered so that it leaves as a clean data output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_region   <= CFAM_REGION_NONE;
      cpu_sfa_impl <= 1'b0;
    end else begin
      cpu_region   <= cpu_region_c; // RL11 RL12 RL13 RL14
      cpu_sfa_impl <= cpu_sfa_impl_c;
    end
  end

endmodule

// >>> testbench/cfam_core_properties.sv
`timescale 1ns/1ps
module cfam_core_properties
  import cfam_pkg::*;
#(
  parameter logic [23:0] RAM_SIZE = CFAM_RAM_SIZE,
  parameter logic [23:0] ROM_SIZE = CFAM_ROM_SIZE,
  parameter logic [23:0] SFA_SIZE = CFAM_SFA_SIZE
) (
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [11:0]     paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic            irq_req,
  input wire logic [2:0]      irq_level,
  input wire logic            irq_accept,
  input wire logic            user_stack_sel,
  input wire logic            bank_sel,
  input wire logic            instr_done,
  input wire logic            trap_ack,
  input wire logic            debug_trap,
  input wire logic [23:0]     cpu_addr,
  input wire cfam_region_type cpu_region,
  input wire logic            cpu_sfa_impl
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_in_access: assert property (pready == (psel && penable))
    else $error("pready differs from access phase");
  a_error_in_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  // Level zero never outranks the priority field, so it is never taken.
  a_irq_needs_req: assert property (irq_accept |-> irq_req && irq_level != 3'h0)
    else $error("interrupt accepted without a request above level zero");
  a_trap_after_done: assert property ($rose(debug_trap) |-> $past(instr_done))
    else $error("debug trap without a finished instruction");
  a_trap_holds: assert property (debug_trap && !trap_ack |=> debug_trap)
    else $error("debug trap dropped before acknowledge");
  a_trap_clears: assert property (debug_trap && trap_ack |=> !debug_trap)
    else $error("debug trap kept after acknowledge");
  a_region_sfa: assert property (cpu_addr <= CFAM_SFA_HI |=> cpu_region == CFAM_REGION_SFA)
    else $error("special function area not decoded");
  a_sfa_fill_top: assert property (cpu_addr <= CFAM_SFA_HI && cpu_addr >= 24'h400 - SFA_SIZE
    |=> cpu_sfa_impl)
    else $error("implemented special register not flagged");
  a_region_ram: assert property (cpu_addr >= CFAM_RAM_BASE
    && cpu_addr <= CFAM_RAM_BASE + RAM_SIZE - 24'h1 |=> cpu_region == CFAM_REGION_RAM)
    else $error("ram area not decoded");
  a_region_rom: assert property (cpu_addr >= 24'h0 - ROM_SIZE && cpu_addr < CFAM_VEC_LO
    |=> cpu_region == CFAM_REGION_ROM)
    else $error("rom area not decoded");
  a_region_vector: assert property (cpu_addr >= CFAM_VEC_LO |=> cpu_region == CFAM_REGION_VECTOR)
    else $error("vector area not decoded");

  c_irq_taken: cover property (irq_accept);
  c_trap_raised: cover property ($rose(debug_trap));
  c_refused: cover property (pslverr);
endmodule

bind cfam_core cfam_core_properties #(.RAM_SIZE(RAM_SIZE), .ROM_SIZE(ROM_SIZE),
  .SFA_SIZE(SFA_SIZE)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq_req(irq_req), .irq_level(irq_level),
  .irq_accept(irq_accept), .user_stack_sel(user_stack_sel), .bank_sel(bank_sel),
  .instr_done(instr_done), .trap_ack(trap_ack), .debug_trap(debug_trap),
  .cpu_addr(cpu_addr), .cpu_region(cpu_region), .cpu_sfa_impl(cpu_sfa_impl));

// >>> testbench/cpu_flags_and_address_map_tb.sv
`timescale 1ns/1ps
module cpu_flags_and_address_map_tb;
  import cfam_pkg::*;
  logic            pclk, presetn, psel, penable, pwrite, irq_req, instr_done, trap_ack;
  logic            pready, pslverr, irq_accept, user_stack_sel, bank_sel, debug_trap;
  logic            cpu_sfa_impl, c, o;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata;
  logic [2:0]      irq_level, lv;
  logic [23:0]     cpu_addr;
  logic [15:0]     a, b;
  logic [16:0]     s;
  logic [32:0]     exp_q[$];
  cfam_region_type cpu_region;
  int              fail_count, tests_run, i, k;
  logic [23:0]     pt[10] = '{24'h0, 24'h3ff, 24'h400, 24'h2bff, 24'h2c00, 24'hfdffff,
                              24'hfe0000, 24'hfffdff, 24'hfffe00, 24'hffffff};
  logic [4:0]      er[10] = '{5'h2, 5'h2, 5'h4, 5'h4, 5'h1, 5'h1, 5'h8, 5'h8, 5'h10, 5'h10};

  cfam_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_req(irq_req), .irq_level(irq_level), .irq_accept(irq_accept),
    .user_stack_sel(user_stack_sel), .bank_sel(bank_sel), .instr_done(instr_done),
    .trap_ack(trap_ack), .debug_trap(debug_trap), .cpu_addr(cpu_addr),
    .cpu_region(cpu_region), .cpu_sfa_impl(cpu_sfa_impl));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [32:0] seen, input logic [32:0] expv);
    tests_run++;
    if (seen !== expv) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, expv);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================================
  // APB master: setup, access until pready, then one idle cycle.
  task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) begin
      fail_count++;
      final_report();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    xfer(1'b1, ad, d);
  endtask

  task automatic rd(input logic [11:0] ad, input logic [32:0] e);
    exp_q.push_back(e);
    xfer(1'b0, ad, 32'h0);
  endtask

  // Read data and error are compared at the edge that completes the read.
  always @(posedge pclk) begin
    if (presetn && psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("unexpected at %0t: read without expectation", $time);
      end else begin
        chk({pslverr, prdata}, exp_q.pop_front());
      end
    end
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    {psel, penable, pwrite, irq_req, instr_done, trap_ack} = '0;
    {paddr, pwdata, irq_level, cpu_addr} = '0;
    presetn = 1'b0;
    fail_count = 0;
    tests_run = 0;
    void'($urandom(92));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(CFAM_OFF_FLAG, 33'h0);
    wr(CFAM_OFF_FLAG, 32'hffffffff);
    rd(CFAM_OFF_FLAG, 33'h70ff);
    chk(33'({user_stack_sel, bank_sel}), 33'h3);
    irq_req <= 1'b1;
    for (i = 0; i < 16; i++) begin
      k = i % 8;
      lv = 3'($urandom);
      irq_level <= lv;
      wr(CFAM_OFF_FLAG, 32'(k << 12) | (i < 8 ? 32'h40 : 32'h0));
      rd(CFAM_OFF_STATUS, 33'({i < 8 && lv > k, 2'b00, i < 8}));
      chk(33'(irq_accept), 33'(i < 8 && lv > k));
    end
    irq_req <= 1'b0;
    chk(33'({user_stack_sel, bank_sel}), 33'h0);
    for (i = 0; i < 24; i++) begin
      k = i % 4;
      a = 16'($urandom);
      b = (i == 5) ? a : 16'($urandom);
      if (i < 4) begin
        a = 16'h7fff;
        b = 16'hffff;
      end
      c = 1'($urandom);
      wr(CFAM_OFF_FLAG, 32'(c));
      wr(CFAM_OFF_OPERAND_A, 32'(a));
      wr(CFAM_OFF_OPERAND_B, 32'(b));
      wr(CFAM_OFF_ALU_CTRL, 32'(k << 1) | 32'h1);
      case (k)
        0: s = a + b;
        1: s = a - b;
        2: s = a + b + c;
        default: s = a - b - c;
      endcase
      o = k[0] ? (a[15] != b[15] && s[15] != a[15]) : (a[15] == b[15] && s[15] != a[15]);
      rd(CFAM_OFF_RESULT, 33'(s[15:0]));
      rd(CFAM_OFF_FLAG, 33'({o, 1'b0, s[15], s[15:0] == 16'h0, 1'b0, s[16]}));
    end
    for (i = 0; i < 10; i++) begin
      cpu_addr <= pt[i];
      wr(CFAM_OFF_PROBE, 32'(pt[i]));
      rd(CFAM_OFF_REGION, 33'({pt[i] <= 24'h3ff, er[i]}));
      chk(33'({cpu_sfa_impl, cpu_region}), 33'({pt[i] <= 24'h3ff, er[i]}));
    end
    wr(CFAM_OFF_FLAG, 32'h0);
    wr(CFAM_OFF_BANK_LO, 32'h1234abcd);
    wr(12'h050, 32'h00aa5555);
    wr(CFAM_OFF_FLAG, 32'h10);
    wr(CFAM_OFF_BANK_LO, 32'h0000beef);
    wr(12'h050, 32'h00123456);
    rd(CFAM_OFF_BANK_LO, 33'hbeef);
    rd(12'h050, 33'h123456);
    wr(CFAM_OFF_FLAG, 32'h0);
    rd(CFAM_OFF_BANK_LO, 33'habcd);
    rd(12'h050, 33'haa5555);
    rd(12'h100, 33'h100000000);
    rd(12'h042, 33'h100000000);
    wr(CFAM_OFF_FLAG, 32'h2);
    instr_done <= 1'b1;
    @(posedge pclk);
    instr_done <= 1'b0;
    @(posedge pclk);
    chk(33'(debug_trap), 33'h1);
    rd(CFAM_OFF_STATUS, 33'h10);
    trap_ack <= 1'b1;
    @(posedge pclk);
    trap_ack <= 1'b0;
    @(posedge pclk);
    chk(33'(debug_trap), 33'h0);
    final_report();
  end
endmodule
